// File: rtl/lsr_consts.svh
`ifndef LSR_CONSTS_SVH
`define LSR_CONSTS_SVH
// ----------------------------------------------------------------
// widths and bit positions
// ----------------------------------------------------------------
`define LSR_SR_W      257
`define LSR_SEL_BIT   256
`define LSR_GS_W      256
`define LSR_CC1_W     137
`define LSR_CC2_W     119
`define LSR_DC_W      112
`define LSR_BC_LSB    112
`define LSR_FC_LSB    119
`define LSR_FC_MSB    136
`define LSR_CNT_W     16
// ----------------------------------------------------------------
// counts and reset values
// ----------------------------------------------------------------
`define LSR_CNT_ZERO  16'h0000
`define LSR_CNT_ONE   16'h0001
`define LSR_CNT_LAST  16'hFFFF
`define LSR_FC_RST    18'h0_0001
`define LSR_LOW_RST   119'h0
`define LSR_GS_RST    256'h0
`endif

// File: rtl/lsr_pkg.sv
`default_nettype none
package lsr_pkg;
   // display controller states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_ARM  = 3'h2,
      ST_RUN  = 3'h4
   } lsr_state_t;

   // function control field, latch bits 136..119
   typedef struct packed {
      logic       power_save_select;
      logic [6:0] detect_misc;
      logic [1:0] fault_capture_timing;
      logic [1:0] short_detect_level;
      logic [1:0] open_detect_level;
      logic       spread_pwm_select;
      logic       timing_reset_enable;
      logic       auto_repeat_enable;
      logic       blank;
   } lsr_fc_t;

   // second-stage data seen by the output stage
   typedef struct packed {
      logic [255:0] gray_level;
      logic [6:0]   global_brightness;
      logic [111:0] dot_correction;
   } lsr_disp_t;
endpackage
`default_nettype wire

// File: rtl/lsr_shift_latch.sv
// Behaviour
// [RULE1] shift clock rise moves serial input into lsb; msb drives serial out
// [RULE2] strobe with msb 0 loads low 256 bits into first gray latch
// [RULE3] strobe with msb 1 loads low 137 bits into first control latch
// [RULE4] first control latch 137 bits; second holds 119 dot/brightness bits
// [RULE5] gray copy on period end with repeat, timing reset write, blank
// [RULE6] control copy of 119 bits on period end or blank set
// [RULE7] data written mid-period waits in first stage until period end
// [RULE8] blank rising before period end transfers first stage at once
// [RULE9] strobe while blank writes both latch stages together
// [RULE10] function bits 119..136 act as soon as first stage written
// [RULE11] timing reset gray write clears counter and forces outputs off
// [RULE12] timing reset gray write fills both gray stages, copies control
// [RULE13] after timing reset or blank release restart at next count edge
// [RULE14] without timing reset a strobe leaves counter and outputs alone
// [RULE15] outputs driven only from second stage latches
// [RULE16] gray latch holds sixteen 16-bit channels, channel 0 lowest
// [RULE17] dot correction 7 bits per channel, channel 0 lowest
// [RULE18] power-up data arbitrary except blank at 1 and power save
// [RULE19] controller loads gray data before enabling outputs
// [RULE20] controller loads both control stages before enabling outputs
// [RULE21] blank forces outputs off, clears counter, resets timing
// [RULE22] global brightness at control bits 118..112 for all channels
// [RULE23] bit 120 repeats period every 65536 counts, else one period
// [RULE24] bit 121 enables timing reset on gray write strobes
// [RULE25] counter counts 0..65535; completing edge ends the period
`include "lsr_consts.svh"
`default_nettype none
module lsr_shift_latch (
   // system clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // serial link, on its own shift clock
   input  wire logic        sclk,
   input  wire logic        serial_in_pin,
   output logic             serial_out_pin,
   // strobe and count clock pins
   input  wire logic        latch_strobe,
   input  wire logic        pwm_count_clock,
   // state toward the output stage
   output lsr_pkg::lsr_disp_t disp,
   output lsr_pkg::lsr_fc_t   fc,
   output logic [15:0]      pwm_count,
   output logic             outputs_off
);
   import lsr_pkg::*;

   // ----------------------------------------------------------------
   // link domain: common shift register
   // ----------------------------------------------------------------
   logic [`LSR_SR_W-1:0] sr_q;
   logic [`LSR_SR_W-1:0] sr_d;

   // shift toward msb, no reset: contents arbitrary at power-up
   always_comb begin
      sr_d = {sr_q[`LSR_SR_W-2:0], serial_in_pin}; // see [RULE1]
   end

   always_ff @(posedge sclk) begin
      sr_q <= sr_d; // see [RULE18]
   end

   assign serial_out_pin = sr_q[`LSR_SEL_BIT]; // see [RULE1]

   // ----------------------------------------------------------------
   // pin synchronisers and edge detect
   // ----------------------------------------------------------------
   logic [2:0] lat_s_q;
   logic [2:0] lat_s_d;
   logic [2:0] pwm_s_q;
   logic [2:0] pwm_s_d;
   logic       lat_ev;
   logic       pwm_ev;

   // stage 0 feeds only stage 1; edges look at stages 1 and 2
   always_comb begin
      lat_s_d = {lat_s_q[1:0], latch_strobe};
      pwm_s_d = {pwm_s_q[1:0], pwm_count_clock};
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         lat_s_q <= 3'h0;
         pwm_s_q <= 3'h0;
      end else begin
         lat_s_q <= lat_s_d;
         pwm_s_q <= pwm_s_d;
      end
   end

   assign lat_ev = lat_s_q[1] & ~lat_s_q[2];
   assign pwm_ev = pwm_s_q[1] & ~pwm_s_q[2];

   // ----------------------------------------------------------------
   // latches and display timing
   // ----------------------------------------------------------------
   logic [`LSR_GS_W-1:0]  gs1_q;
   logic [`LSR_GS_W-1:0]  gs1_d;
   logic [`LSR_GS_W-1:0]  gs2_q;
   logic [`LSR_GS_W-1:0]  gs2_d;
   logic [`LSR_CC1_W-1:0] cc1_q;
   logic [`LSR_CC1_W-1:0] cc1_d;
   logic [`LSR_CC2_W-1:0] cc2_q;
   logic [`LSR_CC2_W-1:0] cc2_d;
   logic [`LSR_CNT_W-1:0] cnt_q;
   logic [`LSR_CNT_W-1:0] cnt_d;
   lsr_state_t            st_q;
   lsr_state_t            st_d;
   logic                  off_q;
   logic                  off_d;
   lsr_fc_t               fc_now;
   lsr_fc_t               fc_new;

   // the link clock idles around a strobe, so sr_q is stable
   // for the two synchroniser cycles before it is sampled here
   always_comb begin
      gs1_d  = gs1_q;
      gs2_d  = gs2_q;
      cc1_d  = cc1_q;
      cc2_d  = cc2_q;
      cnt_d  = cnt_q;
      st_d   = st_q;
      fc_now = lsr_fc_t'(cc1_q[`LSR_FC_MSB:`LSR_FC_LSB]);
      fc_new = lsr_fc_t'(sr_q[`LSR_FC_MSB:`LSR_FC_LSB]);
      // count clock edges; end of period on the 65536th
      if (pwm_ev) begin
         case (st_q)
            ST_ARM: begin
               st_d = ST_RUN; // see [RULE13]
            end
            ST_RUN: begin
               if (cnt_q == `LSR_CNT_LAST) begin // see [RULE25]
                  cnt_d = `LSR_CNT_ZERO;
                  cc2_d = cc1_q[`LSR_CC2_W-1:0]; // see [RULE6]
                  if (fc_now.auto_repeat_enable) begin // see [RULE23]
                     gs2_d = gs1_q; // see [RULE5] [RULE7]
                  end else begin
                     st_d = ST_IDLE;
                  end
               end else begin
                  cnt_d = cnt_q + `LSR_CNT_ONE;
               end
            end
            default: begin
               cnt_d = `LSR_CNT_ZERO;
            end
         endcase
      end
      // strobe: msb picks gray or control latch
      if (lat_ev) begin
         if (!sr_q[`LSR_SEL_BIT]) begin
            gs1_d = sr_q[`LSR_GS_W-1:0]; // see [RULE2] [RULE16]
            if (fc_now.blank | fc_now.timing_reset_enable) begin
               gs2_d = sr_q[`LSR_GS_W-1:0]; // see [RULE9] [RULE12]
            end
            if (fc_now.timing_reset_enable) begin // see [RULE24]
               cc2_d = cc1_q[`LSR_CC2_W-1:0]; // see [RULE12]
               cnt_d = `LSR_CNT_ZERO; // see [RULE11]
               if (!fc_now.blank) begin
                  st_d = ST_ARM; // see [RULE11] [RULE13]
               end
            end // else counter untouched, see [RULE14]
         end else begin
            cc1_d = sr_q[`LSR_CC1_W-1:0]; // see [RULE3] [RULE4]
            if (fc_now.blank | fc_new.blank) begin
               cc2_d = sr_q[`LSR_CC2_W-1:0]; // see [RULE9] [RULE8]
            end
            if (fc_new.blank & ~fc_now.blank) begin
               gs2_d = gs1_q; // see [RULE8] [RULE5]
            end
            if (fc_new.blank) begin
               st_d  = ST_IDLE; // see [RULE21]
               cnt_d = `LSR_CNT_ZERO;
            end else if (fc_now.blank) begin
               st_d  = ST_ARM; // see [RULE13]
               cnt_d = `LSR_CNT_ZERO;
            end
         end
      end
      off_d = (st_d != ST_RUN); // see [RULE21] [RULE11]
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         gs1_q <= `LSR_GS_RST;
         gs2_q <= `LSR_GS_RST;
         cc1_q <= {`LSR_FC_RST, `LSR_LOW_RST}; // see [RULE18]
         cc2_q <= `LSR_LOW_RST;
         cnt_q <= `LSR_CNT_ZERO;
         st_q  <= ST_IDLE;
         off_q <= 1'b1;
      end else begin
         gs1_q <= gs1_d;
         gs2_q <= gs2_d;
         cc1_q <= cc1_d;
         cc2_q <= cc2_d;
         cnt_q <= cnt_d;
         st_q  <= st_d;
         off_q <= off_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs: second stage data, first stage function bits
   // ----------------------------------------------------------------
   assign disp.gray_level        = gs2_q; // see [RULE15] [RULE16]
   assign disp.global_brightness =
      cc2_q[`LSR_CC2_W-1:`LSR_BC_LSB]; // see [RULE22]
   assign disp.dot_correction    =
      cc2_q[`LSR_DC_W-1:0]; // see [RULE17] [RULE15]
   assign fc          =
      lsr_fc_t'(cc1_q[`LSR_FC_MSB:`LSR_FC_LSB]); // see [RULE10]
   assign pwm_count   = cnt_q;
   assign outputs_off = off_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_gray_wr;
      lat_ev && !sr_q[`LSR_SEL_BIT]
         |=> gs1_q == $past(sr_q[`LSR_GS_W-1:0]);
   endproperty
   a_gray_wr: assert property (p_gray_wr) // see [RULE2]
      else $error("gray write not latched");

   property p_ctl_wr;
      lat_ev && sr_q[`LSR_SEL_BIT]
         |=> cc1_q == $past(sr_q[`LSR_CC1_W-1:0]) ##1 fc == $past(fc);
   endproperty
   a_ctl_wr: assert property (p_ctl_wr) // see [RULE3]
      else $error("control write not latched");

   property p_blank_wr;
      lat_ev && fc.blank && !sr_q[`LSR_SEL_BIT]
         |=> disp.gray_level == $past(sr_q[`LSR_GS_W-1:0]);
   endproperty
   a_blank_wr: assert property (p_blank_wr) // see [RULE9]
      else $error("blanked write missed second stage");

   property p_tmg_rst;
      lat_ev && !sr_q[`LSR_SEL_BIT] && fc.timing_reset_enable
         |=> pwm_count == `LSR_CNT_ZERO && outputs_off;
   endproperty
   a_tmg_rst: assert property (p_tmg_rst) // see [RULE11]
      else $error("timing reset did not clear display");

   property p_no_tmg;
      lat_ev && !fc.timing_reset_enable && !fc.blank && !pwm_ev
         && !sr_q[`LSR_SEL_BIT] |=> $stable(pwm_count) && $stable(st_q);
   endproperty
   a_no_tmg: assert property (p_no_tmg) // see [RULE14]
      else $error("strobe disturbed counter");

   property p_end;
      pwm_ev && st_q == ST_RUN && pwm_count == `LSR_CNT_LAST
         && fc.auto_repeat_enable && !lat_ev
         |=> disp.gray_level == $past(gs1_q) && st_q == ST_RUN
             && pwm_count == `LSR_CNT_ZERO;
   endproperty
   a_end: assert property (p_end) // see [RULE5]
      else $error("period end transfer missing");

   property p_blank;
      fc.blank |=> outputs_off && pwm_count == `LSR_CNT_ZERO;
   endproperty
   a_blank: assert property (p_blank) // see [RULE21]
      else $error("blank did not hold outputs off");

   property p_arm;
      st_q == ST_ARM && pwm_ev && !lat_ev
         |=> !outputs_off && st_q == ST_RUN;
   endproperty
   a_arm: assert property (p_arm) // see [RULE13]
      else $error("display did not restart");

   property p_count;
      pwm_ev && st_q == ST_RUN && pwm_count != `LSR_CNT_LAST && !lat_ev
         |=> pwm_count == $past(pwm_count) + `LSR_CNT_ONE;
   endproperty
   a_count: assert property (p_count) // see [RULE25]
      else $error("display counter did not step");

   property p_tmg_gray;
      lat_ev && !sr_q[`LSR_SEL_BIT] && fc.timing_reset_enable
         |=> disp.gray_level == $past(sr_q[`LSR_GS_W-1:0])
             && disp.dot_correction == $past(cc1_q[`LSR_DC_W-1:0]);
   endproperty
   a_tmg_gray: assert property (p_tmg_gray) // see [RULE12]
      else $error("timing reset write missed second stage");

   property p_blank_set;
      lat_ev && sr_q[`LSR_SEL_BIT] && sr_q[`LSR_FC_LSB] && !fc.blank
         |=> disp.gray_level == $past(gs1_q)
             && disp.dot_correction == $past(sr_q[`LSR_DC_W-1:0]);
   endproperty
   a_blank_set: assert property (p_blank_set) // see [RULE8]
      else $error("blank set did not refresh second stage");

   property p_one_shot;
      pwm_ev && st_q == ST_RUN && pwm_count == `LSR_CNT_LAST
         && !fc.auto_repeat_enable && !lat_ev
         |=> outputs_off && st_q == ST_IDLE;
   endproperty
   a_one_shot: assert property (p_one_shot) // see [RULE23]
      else $error("single period did not stop");
endmodule // lsr_shift_latch
`default_nettype wire

// File: sim/lsr_ctl.sv
`default_nettype none
// ----------------------------------------------------------------
// display controller model: shifts frames and strobes the latch
// ----------------------------------------------------------------
module lsr_ctl (
   // system clock, used only to time the strobe
   input  wire logic clk,
   // link pins toward the driver
   output logic      sclk,
   output logic      serial_in_pin,
   output logic      latch_strobe
);
   timeunit 1ns;
   timeprecision 1ps;

   // shift clock idles low between frames
   initial begin
      sclk = 1'b0;
      serial_in_pin = 1'b0;
      latch_strobe = 1'b0;
   end

   // one 257-bit frame msb first at 32 ns, then one strobe
   task automatic send(input logic [256:0] w);
      for (int i = 256; i >= 0; i--) begin
         serial_in_pin = w[i];
         #16 sclk = 1'b1;
         #16 sclk = 1'b0;
      end
      serial_in_pin = ~w[0]; // stale line shows the inverse
      repeat (5) @(posedge clk); // shift clock quiet before strobe
      latch_strobe <= 1'b1;
      repeat (4) @(posedge clk);
      latch_strobe <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
endmodule // lsr_ctl
`default_nettype wire

// File: sim/lsr_shift_latch_tb.sv
`default_nettype none
module lsr_shift_latch_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lsr_pkg::*;
   // ----------------------------------------------------------------
   // bench signals
   // ----------------------------------------------------------------
   logic        clk, resetn, pwm_count_clock, sclk;
   logic        serial_in_pin, latch_strobe, serial_out_pin, outputs_off;
   lsr_disp_t   disp;
   lsr_fc_t     fc;
   logic [15:0] pwm_count;
   int          err_total, checks;

   lsr_ctl lsr_ctl_i (.clk(clk), .sclk(sclk),
      .serial_in_pin(serial_in_pin), .latch_strobe(latch_strobe));
   lsr_shift_latch lsr_shift_latch_i (.clk(clk), .resetn(resetn),
      .sclk(sclk), .serial_in_pin(serial_in_pin),
      .serial_out_pin(serial_out_pin), .latch_strobe(latch_strobe),
      .pwm_count_clock(pwm_count_clock), .disp(disp), .fc(fc),
      .pwm_count(pwm_count), .outputs_off(outputs_off));

   // 25 MHz system clock
   initial clk = 1'b0;
   always #20 clk = ~clk;

   // frame builders; f is {timing reset, repeat, blank}
   function automatic logic [256:0] ctl(input logic [2:0] f,
                                        input logic [6:0] bc,
                                        input logic [6:0] k);
      logic [256:0] w;
      w = {1'b1, 119'h0, 15'h0, f, bc, 112'h0};
      for (int n = 0; n < 16; n++) w[7*n +: 7] = k + 7'(n);
      return w;
   endfunction
   function automatic logic [256:0] gray(input logic [15:0] k);
      logic [256:0] w;
      w = '0;
      for (int n = 0; n < 16; n++) w[16*n +: 16] = k + 16'(n);
      return w;
   endfunction

   task automatic chk(input string nm, input logic [255:0] seen,
                      input logic [255:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      if (err_total == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // count edges four clocks apart, then let the sync settle
   task automatic pulse(input int n);
      repeat (n) begin
         pwm_count_clock <= 1'b1;
         repeat (2) @(posedge clk);
         pwm_count_clock <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask
   task automatic chk_ctl(input logic [256:0] w);
      chk("fc", 256'(fc), 256'(w[136:119]));
      chk("bc", 256'(disp.global_brightness),
          256'(w[118:112]));
      chk("dc", 256'(disp.dot_correction), 256'(w[111:0]));
   endtask
   task automatic chk_cnt(input logic [15:0] c, input logic off);
      chk("count", 256'(pwm_count), 256'(c));
      chk("off", 256'(outputs_off), 256'(off));
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_blank_load;
      lsr_ctl_i.send(ctl(3'h3, 7'h55, 7'h03));
      chk("serial_out_pin", 256'(serial_out_pin), 256'h1);
      chk_ctl(ctl(3'h3, 7'h55, 7'h03));
      lsr_ctl_i.send(gray(16'h1000));
      chk("serial_out_pin", 256'(serial_out_pin), 256'h0);
      chk("gray", disp.gray_level, 256'(gray(16'h1000)));
   endtask
   task automatic t_run_and_hold;
      lsr_ctl_i.send(ctl(3'h2, 7'h55, 7'h03));
      chk_cnt(16'h0000, 1'b1);
      pulse(6);
      chk_cnt(16'h0005, 1'b0);
      lsr_ctl_i.send(gray(16'h2000));
      chk("gray", disp.gray_level, 256'(gray(16'h1000)));
      chk_cnt(16'h0005, 1'b0);
      lsr_ctl_i.send(ctl(3'h6, 7'h2A, 7'h40));
      chk("fc", 256'(fc), 256'(18'h0_0006));
      chk("dc", 256'(disp.dot_correction),
          256'(ctl(3'h0, 7'h00, 7'h03)));
   endtask
   task automatic t_timing_reset;
      lsr_ctl_i.send(gray(16'h3000));
      chk("gray", disp.gray_level, 256'(gray(16'h3000)));
      chk_ctl(ctl(3'h6, 7'h2A, 7'h40));
      chk_cnt(16'h0000, 1'b1);
      pulse(4);
      chk_cnt(16'h0003, 1'b0);
   endtask
   // gray data parked in stage one moves up when blank is set
   task automatic t_blank_set;
      lsr_ctl_i.send(ctl(3'h2, 7'h11, 7'h20));
      lsr_ctl_i.send(gray(16'h4000));
      chk("gray", disp.gray_level, 256'(gray(16'h3000)));
      chk("bc", 256'(disp.global_brightness), 256'(7'h2A));
      chk_cnt(16'h0003, 1'b0);
      lsr_ctl_i.send(ctl(3'h7, 7'h11, 7'h20));
      chk("gray", disp.gray_level, 256'(gray(16'h4000)));
      chk_ctl(ctl(3'h7, 7'h11, 7'h20));
      chk_cnt(16'h0000, 1'b1);
   endtask

   // bounded run
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      finish_test;
   end

   // main sequence
   initial begin
      err_total = 0;
      checks = 0;
      resetn = 1'b0;
      pwm_count_clock = 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      chk("fc", 256'(fc), 256'(18'h0_0001));
      chk_cnt(16'h0000, 1'b1);
      t_blank_load;
      t_run_and_hold;
      t_timing_reset;
      t_blank_set;
      finish_test;
   end
endmodule // lsr_shift_latch_tb
`default_nettype wire
